// >>> design/ipa_irq_aggregator.sv
// Interrupt aggregation with de-assertion interval timer and APB register access
`timescale 1ns/1ns

module ipa_irq_aggregator #(
   parameter int STEP_CYCLES = ipa_pkg::STEP_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic soft_reset,
   input wire logic crystal_clk,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire ipa_pkg::ipa_src_t src,
   output ipa_pkg::ipa_pin_t irq_pin
);

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode
   typedef enum {
      SEL_NONE,
      SEL_CFG,
      SEL_STS,
      SEL_EN
   } ipa_sel_t;

   // One decoder for both the write strobes and the read mux, so they never disagree
   function automatic ipa_sel_t reg_sel(input logic [7:0] addr);
      case (addr)
         ipa_pkg::CFG_OFS: begin
            reg_sel = SEL_CFG;
         end
         ipa_pkg::STS_OFS: begin
            reg_sel = SEL_STS;
         end
         ipa_pkg::EN_OFS: begin
            reg_sel = SEL_EN;
         end
         default: begin
            reg_sel = SEL_NONE;
         end
      endcase
   endfunction

   logic wr_acc;
   logic rd_acc;
   logic hit_cfg;
   logic hit_sts;
   logic hit_en;
   ipa_sel_t sel;
   assign sel = reg_sel(paddr);
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign hit_cfg = (sel == SEL_CFG);
   assign hit_sts = (sel == SEL_STS);
   assign hit_en = (sel == SEL_EN);
   assign pready = 1'b1;
   // Unmapped addresses answer with an error and read zero
   assign pslverr = psel && penable && !(hit_cfg || hit_sts || hit_en);

   ////////////////////////////////////////////////////////////////////////////
   // Configuration
   logic [7:0] interval_len_r;
   logic out_en_r;
   logic clk_sel_r;
   logic pin_polarity_r;
   logic push_pull_r;
   logic restart_pulse;
   logic interval_zero_wr;
   assign restart_pulse = wr_acc && hit_cfg && pwdata[ipa_pkg::RESTART_BIT];
   assign interval_zero_wr = wr_acc && hit_cfg
      && (pwdata[31:ipa_pkg::INTERVAL_LSB] == 8'h00);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interval_len_r <= ipa_pkg::INTERVAL_RST;
         out_en_r <= 1'b0;
         clk_sel_r <= 1'b0;
      end else if (soft_reset) begin
         interval_len_r <= ipa_pkg::INTERVAL_RST;
         out_en_r <= 1'b0;
         clk_sel_r <= 1'b0;
      end else if (wr_acc && hit_cfg) begin
         interval_len_r <= pwdata[31:ipa_pkg::INTERVAL_LSB];
         out_en_r <= pwdata[ipa_pkg::OUT_EN_BIT];
         clk_sel_r <= pwdata[ipa_pkg::CLK_SEL_BIT];
      end
   end

   // Kept over soft reset: only the hard reset clears these
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_polarity_r <= 1'b0;
         push_pull_r <= 1'b0;
      end else if (wr_acc && hit_cfg) begin
         pin_polarity_r <= pwdata[ipa_pkg::POL_BIT];
         push_pull_r <= pwdata[ipa_pkg::TYPE_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Enables and status
   logic [31:0] enable_r;
   logic [31:0] status_r;
   logic soft_trig_d_r;
   logic ready_seen_r;
   logic [31:0] w1c;
   logic [31:0] set_ev;
   logic [31:0] status_nxt;
   assign w1c = (wr_acc && hit_sts) ? (pwdata & ipa_pkg::W1C_MASK) : 32'h00000000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_r <= ipa_pkg::EN_RST;
      end else if (soft_reset) begin
         enable_r <= ipa_pkg::EN_RST;
      end else if (wr_acc && hit_en) begin
         enable_r <= pwdata & ipa_pkg::SRC_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_trig_d_r <= 1'b0;
         ready_seen_r <= 1'b0;
      end else begin
         soft_trig_d_r <= enable_r[ipa_pkg::SOFT_BIT];
         // Ready is raised once per reset, on the first cycle the device is accessible
         if (soft_reset) begin
            ready_seen_r <= 1'b0;
         end else if (src.device_ready) begin
            ready_seen_r <= 1'b1;
         end
      end
   end

   always_comb begin
      set_ev = 32'h00000000;
      // Rising edge of the trigger, never its level
      set_ev[ipa_pkg::SOFT_BIT] = enable_r[ipa_pkg::SOFT_BIT] && !soft_trig_d_r;
      set_ev[ipa_pkg::READY_BIT] = src.device_ready && !ready_seen_r;
      set_ev[ipa_pkg::TIMER_BIT] = src.timer_wrap;
      set_ev[ipa_pkg::POWER_BIT] = src.power_event;
      status_nxt = (status_r & ~w1c) | set_ev; // set wins over clear
      // Power flag refuses the clear while unmasked power flags remain
      if (!src.power_flags_clear && status_r[ipa_pkg::POWER_BIT]) begin
         status_nxt[ipa_pkg::POWER_BIT] = 1'b1;
      end
      // Mirrored bits follow their sources directly
      status_nxt[ipa_pkg::PHY_B_BIT] = src.phy_b_event;
      status_nxt[ipa_pkg::PHY_A_BIT] = src.phy_a_event;
      status_nxt[ipa_pkg::CORE_BIT] = src.core_event;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_r <= 32'h00000000;
      end else if (soft_reset) begin
         status_r <= 32'h00000000;
      end else begin
         status_r <= status_nxt & ipa_pkg::SRC_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Combined request and interval gating
   logic master_req_r;
   logic [31:0] gated_src;
   assign gated_src = status_r & enable_r & ~(32'h1 << ipa_pkg::POWER_BIT);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         master_req_r <= 1'b0;
      end else begin
         master_req_r <= |(status_r & enable_r);
      end
   end

   logic interval_active_r;
   logic [7:0] step_cnt_r;
   logic [$clog2(STEP_CYCLES+1)-1:0] tick_cnt_r;
   logic pin_asserted_r;
   logic gated_req;
   logic power_req;
   logic pin_level;
   logic deassert_edge;
   logic tick;
   assign gated_req = (|gated_src) && !interval_active_r;
   assign power_req = status_r[ipa_pkg::POWER_BIT] && enable_r[ipa_pkg::POWER_BIT];
   // Power request is merged after gating
   assign pin_level = out_en_r && (gated_req || power_req);
   // A deassertion starts an interval only when no power request is pending
   assign deassert_edge = pin_asserted_r && !pin_level && !power_req;
   assign tick = (tick_cnt_r == ($bits(tick_cnt_r))'(STEP_CYCLES - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_asserted_r <= 1'b0;
      end else begin
         pin_asserted_r <= pin_level;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interval_active_r <= 1'b0;
         step_cnt_r <= 8'h00;
         tick_cnt_r <= '0;
      end else if (soft_reset || interval_zero_wr) begin
         interval_active_r <= 1'b0;
         step_cnt_r <= 8'h00;
         tick_cnt_r <= '0;
      end else if ((restart_pulse || deassert_edge) && interval_len_r != 8'h00) begin
         interval_active_r <= 1'b1;
         step_cnt_r <= 8'h00;
         tick_cnt_r <= '0;
      end else if (interval_active_r) begin
         tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
         if (tick) begin
            if (step_cnt_r + 8'h01 >= interval_len_r) begin
               interval_active_r <= 1'b0;
               step_cnt_r <= 8'h00;
            end else begin
               step_cnt_r <= step_cnt_r + 8'h01;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin driver
   always_comb begin
      if (clk_sel_r) begin
         irq_pin.o = crystal_clk;
         irq_pin.oe = 1'b1;
      end else if (push_pull_r) begin
         irq_pin.o = pin_polarity_r ? pin_level : !pin_level;
         irq_pin.oe = 1'b1;
      end else begin
         irq_pin.o = 1'b0;
         irq_pin.oe = pin_level;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data
   logic [31:0] cfg_view;
   always_comb begin
      cfg_view = 32'h00000000;
      cfg_view[31:ipa_pkg::INTERVAL_LSB] = interval_len_r;
      cfg_view[ipa_pkg::ACTIVE_BIT] = interval_active_r;
      cfg_view[ipa_pkg::MASTER_BIT] = master_req_r;
      cfg_view[ipa_pkg::OUT_EN_BIT] = out_en_r;
      cfg_view[ipa_pkg::POL_BIT] = pin_polarity_r;
      cfg_view[ipa_pkg::CLK_SEL_BIT] = clk_sel_r;
      cfg_view[ipa_pkg::TYPE_BIT] = push_pull_r;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         // Captured in setup so data stands through the access cycle
         case (reg_sel(paddr))
            SEL_CFG: begin
               prdata <= cfg_view;
            end
            SEL_STS: begin
               prdata <= status_r;
            end
            SEL_EN: begin
               prdata <= enable_r;
            end
            default: begin
               prdata <= 32'h00000000;
            end
         endcase
      end
   end

endmodule // ipa_irq_aggregator

// >>> design/ipa_pkg.sv
// Package for the interrupt pin aggregator: register map, fields, reset values, timing
package ipa_pkg;

   // Register byte offsets
   localparam logic [7:0] CFG_OFS = 8'h54;
   localparam logic [7:0] STS_OFS = 8'h58;
   localparam logic [7:0] EN_OFS = 8'h5C;

   // Configuration register fields
   localparam int INTERVAL_LSB = 24;
   localparam int RESTART_BIT = 14;
   localparam int ACTIVE_BIT = 13;
   localparam int MASTER_BIT = 12;
   localparam int OUT_EN_BIT = 8;
   localparam int POL_BIT = 4;
   localparam int CLK_SEL_BIT = 1;
   localparam int TYPE_BIT = 0;

   // Status / enable bit positions (same layout for both)
   localparam int SOFT_BIT = 31;
   localparam int READY_BIT = 30;
   localparam int PHY_B_BIT = 27;
   localparam int PHY_A_BIT = 26;
   localparam int TIMER_BIT = 19;
   localparam int POWER_BIT = 17;
   localparam int CORE_BIT = 0;

   // Implemented bits; all others read zero
   localparam logic [31:0] SRC_MASK = 32'hCC0A0001;
   localparam logic [31:0] W1C_MASK = 32'hC00A0000;

   // Reset values
   localparam logic [7:0] INTERVAL_RST = 8'h00;
   localparam logic [31:0] EN_RST = 32'h00000000;

   // Interval step timing
   localparam int STEP_NS = 10000;
   localparam int CLK_PERIOD_NS = 4;
   localparam int STEP_CYCLES = STEP_NS / CLK_PERIOD_NS;

   // Inputs from the surrounding sources
   typedef struct packed {
      logic phy_a_event;
      logic phy_b_event;
      logic core_event;
      logic timer_wrap;
      logic power_event;
      logic power_flags_clear;
      logic device_ready;
   } ipa_src_t;

   // Pin drive pair: level and output enable
   typedef struct packed {
      logic o;
      logic oe;
   } ipa_pin_t;

endpackage

// >>> bench/ipa_host_model.sv
// Host-side model of the interrupt input: resolves the pin against its pull-up
`timescale 1ns/1ns
module ipa_host_model (
   input wire ipa_pkg::ipa_pin_t pin,
   output logic level
);
   // A released open-drain line floats to the pull-up rather than keeping the old value
   assign level = pin.oe ? pin.o : 1'b1;
endmodule // ipa_host_model

// >>> bench/ipa_irq_aggregator_checker.sv
// Assertions on the aggregator's bus and pin ports
`timescale 1ns/1ns
module ipa_irq_aggregator_checker #(parameter int STEP_CYCLES = 4) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic soft_reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire ipa_pkg::ipa_pin_t irq_pin
);
   logic [31:0] cfg_r;
   logic mapped;
   logic rd_set;
   assign mapped = paddr == ipa_pkg::CFG_OFS || paddr == ipa_pkg::STS_OFS
      || paddr == ipa_pkg::EN_OFS;
   assign rd_set = psel && !penable && !pwrite;
   // Shadow of the writable config fields, so the pin checks know the drive mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         cfg_r <= 32'h00000000;
      else if (soft_reset)
         cfg_r <= cfg_r & 32'h00000011;
      else if (psel && penable && pwrite && pready && paddr == ipa_pkg::CFG_OFS)
         cfg_r <= pwdata & 32'hFF000113;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////////////
   bus_ready_a: assert property (psel |-> pready)
      else $error("pready low during a transfer");
   unmapped_err_a: assert property (psel && penable && !mapped |-> pslverr)
      else $error("no error response on an unmapped address");
   unmapped_zero_a: assert property (rd_set && !mapped |=> prdata == 32'h00000000)
      else $error("unmapped read returned nonzero data");
   cfg_back_a: assert property (
      rd_set && paddr == ipa_pkg::CFG_OFS |=> (prdata & 32'hFF000113) == $past(cfg_r))
      else $error("config read back differs from what was written");
   src_rsvd_a: assert property (
      rd_set && paddr != ipa_pkg::CFG_OFS |=> (prdata & ~ipa_pkg::SRC_MASK) == 32'h00000000)
      else $error("reserved status or enable bit reads one");
   od_low_a: assert property (!cfg_r[0] && !cfg_r[1] |-> !irq_pin.o)
      else $error("open-drain pin drives high");
   pp_drive_a: assert property (cfg_r[0] && !cfg_r[1] |-> irq_pin.oe)
      else $error("push-pull pin not driven");
   pin_off_a: assert property (
      !cfg_r[8] && !cfg_r[1] |-> (cfg_r[0] ? irq_pin.o == !cfg_r[4] : !irq_pin.oe))
      else $error("disabled pin not held inactive");
endmodule // ipa_irq_aggregator_checker

bind ipa_irq_aggregator ipa_irq_aggregator_checker #(.STEP_CYCLES(STEP_CYCLES)) chk_i (
   .pclk(pclk), .presetn(presetn), .soft_reset(soft_reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .irq_pin(irq_pin));

// >>> bench/ipa_irq_aggregator_test.sv
// Self-checking bench for the interrupt pin aggregator
`timescale 1ns/1ns
module ipa_irq_aggregator_test;
   localparam logic [7:0] A_CFG = ipa_pkg::CFG_OFS;
   localparam logic [7:0] A_STS = ipa_pkg::STS_OFS;
   localparam logic [7:0] A_EN = ipa_pkg::EN_OFS;
   logic pclk, presetn, soft_reset, crystal_clk, psel, penable, pwrite, pready, pslverr, level;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   ipa_pkg::ipa_src_t src;
   ipa_pkg::ipa_pin_t irq_pin;
   int n_fail = 0;
   int compares = 0;
   ipa_irq_aggregator #(.STEP_CYCLES(4)) uut (.pclk(pclk), .presetn(presetn),
      .soft_reset(soft_reset), .crystal_clk(crystal_clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .src(src), .irq_pin(irq_pin));
   ipa_host_model host (.pin(irq_pin), .level(level));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // Debug clock toggles on odd times only, so it never races the pclk edge
   initial begin
      crystal_clk = 1'b0;
      #1;
      forever #6 crystal_clk = ~crystal_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // One transfer, then an idle edge so strobes never change twice in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      chk(rd, exp);
   endtask
   task automatic pin_is(input logic exp);
      chk({31'h0, level}, {31'h0, exp});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_soft;
      rdc(A_EN, 32'h00000000);
      rdc(8'h60, 32'h00000000);
      apb(1'b1, A_EN, 32'h80000000);
      rdc(A_STS, 32'h80000000);
      rdc(A_CFG, 32'h00001000);
      pin_is(1'b1);
      apb(1'b1, A_CFG, 32'h00000100);
      pin_is(1'b0);
      apb(1'b1, A_STS, 32'h00000000);
      rdc(A_STS, 32'h80000000);
      apb(1'b1, A_STS, 32'h80000000);
      rdc(A_STS, 32'h00000000);
      pin_is(1'b1);
      apb(1'b1, A_EN, 32'h80000000);
      rdc(A_STS, 32'h00000000);
      apb(1'b1, A_EN, 32'h00000000);
   endtask
   task automatic t_events;
      src <= 7'h7D;
      cyc(1);
      src <= 7'h71;
      cyc(1);
      rdc(A_STS, 32'h4C0A0001);
      apb(1'b1, A_STS, 32'hFFFFFFFF);
      rdc(A_STS, 32'h0C020001);
      src <= 7'h03;
      apb(1'b1, A_STS, 32'h00020000);
      rdc(A_STS, 32'h00000000);
   endtask
   task automatic t_interval;
      apb(1'b1, A_CFG, 32'h08000111);
      apb(1'b1, A_EN, 32'h80000000);
      cyc(1);
      pin_is(1'b1);
      apb(1'b1, A_STS, 32'h80000000);
      rdc(A_CFG, 32'h08002111);
      apb(1'b1, A_CFG, 32'h08004111);
      apb(1'b1, A_EN, 32'h00000000);
      apb(1'b1, A_EN, 32'h80000000);
      cyc(1);
      rdc(A_CFG, 32'h08003111);
      cyc(17);
      pin_is(1'b0);
      cyc(6);
      pin_is(1'b1);
      apb(1'b1, A_STS, 32'h80000000);
      apb(1'b1, A_EN, 32'h00000000);
      apb(1'b1, A_EN, 32'h80000000);
      cyc(2);
      pin_is(1'b0);
      src <= 7'h04;
      cyc(1);
      src <= 7'h00;
      apb(1'b1, A_EN, 32'h80020000);
      pin_is(1'b1);
      src <= 7'h02;
      apb(1'b1, A_STS, 32'h00020000);
      apb(1'b1, A_CFG, 32'h00000111);
      pin_is(1'b1);
      apb(1'b1, A_EN, 32'h00000000);
   endtask
   task automatic t_softrst;
      apb(1'b1, A_CFG, 32'h05000113);
      pin_is(crystal_clk);
      soft_reset <= 1'b1;
      cyc(1);
      soft_reset <= 1'b0;
      cyc(1);
      rdc(A_CFG, 32'h00000011);
   endtask
   task automatic conclude;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      presetn = 1'b0;
      soft_reset = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      src = 7'h00;
      cyc(4);
      presetn <= 1'b1;
      cyc(1);
      t_soft();
      t_events();
      t_interval();
      t_softrst();
      conclude();
   end
   initial begin
      #20000;
      n_fail++;
      conclude();
   end
endmodule // ipa_irq_aggregator_test
